// ---- rtl/paging_pkg.sv ----
// constants, register layout and walk states of the paging translator
package paging_pkg;
    localparam int PAGE_OFFSET_W = 12;
    localparam int LIN_W = 32;
    localparam int PHYS_W = 24;
    localparam int VPN_W = LIN_W - PAGE_OFFSET_W;
    localparam int FRAME_W = PHYS_W - PAGE_OFFSET_W;
    localparam int INDEX_W = 10;
    localparam int DIR_INDEX_LSB = 22;
    localparam int TBL_INDEX_LSB = 12;
    localparam int ENTRY_PRESENT = 0;
    localparam int ENTRY_RW = 1;
    localparam int ENTRY_US = 2;
    localparam int ENTRY_ACCESSED = 5;
    localparam int ENTRY_WRITTEN = 6;
    localparam int ENTRY_ADDR_LSB = 12;
    localparam int MCW_PROT_ON_BIT = 0;
    localparam int MCW_PAGING_BIT = 31;
    localparam int ERR_P = 0;
    localparam int ERR_WR = 1;
    localparam int ERR_US = 2;
    localparam logic [1:0] SEL_MCW = 2'h0;
    localparam logic [1:0] SEL_FAULT_ADDR = 2'h2;
    localparam logic [1:0] SEL_DIR_BASE = 2'h3;
    localparam logic [1:0] USER_LEVEL = 2'h3;
    localparam logic [7:0] PAGE_FAULT_VECTOR = 8'h0e;
    localparam logic [31:0] FAULT_ADDR_RESET = 32'h0000_0000;
    localparam logic [11:0] DIR_BASE_RESET = 12'h000;
    localparam int CACHE_ENTRIES = 32;
    localparam int CACHE_WAYS = 4;
    localparam int CACHE_SETS = CACHE_ENTRIES / CACHE_WAYS;
    typedef enum logic [2:0] {
        ST_IDLE, ST_LOOKUP, ST_DIR_RD, ST_DIR_WR, ST_TBL_RD, ST_TBL_WR
    } walk_state_t;
endpackage : paging_pkg

// ---- rtl/protection_check.sv ----
// page-level protection decision and page-fault error code
`timescale 1ns/100ps
module protection_check import paging_pkg::*; (
    input wire logic present,
    input wire logic user_ok,
    input wire logic rw_ok,
    input wire logic user_access,
    input wire logic write_access,
    output logic violation,
    output logic [2:0] err_code
);
    always_comb begin
        // only level 3 is checked; levels 0..2 pass
        violation = present && user_access && (!user_ok || (write_access && !rw_ok));
        err_code = 3'h0;
        err_code[ERR_US] = user_access;
        err_code[ERR_WR] = write_access;
        err_code[ERR_P] = present;
    end
endmodule : protection_check

// ---- rtl/translation_cache.sv ----
// four-way set-associative translation cache with tree pseudo-lru
`timescale 1ns/100ps
module translation_cache import paging_pkg::*; #(
    parameter int SETS = CACHE_SETS
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [VPN_W-1:0] lookup_vpn,
    input wire logic touch,
    input wire logic fill,
    input wire logic [FRAME_W-1:0] fill_frame,
    input wire logic fill_user,
    input wire logic fill_rw,
    input wire logic fill_dirty,
    input wire logic flush,
    output logic hit,
    output logic [FRAME_W-1:0] hit_frame,
    output logic hit_user,
    output logic hit_rw,
    output logic hit_dirty
);
    localparam int SET_W = $clog2(SETS);
    localparam int TAG_W = VPN_W - SET_W;
    typedef struct packed {
        logic valid;
        logic [TAG_W-1:0] tag;
        logic [FRAME_W-1:0] frame;
        logic user;
        logic rw;
        logic dirty;
    } entry_t;
    typedef struct packed {
        entry_t [SETS-1:0][CACHE_WAYS-1:0] ent;
        logic [SETS-1:0][2:0] plru;
    } cache_state_t;
    cache_state_t state, next_state;

    function automatic logic [2:0] plru_touch(input logic [2:0] bits, input logic [1:0] way);
        logic [2:0] t;
        t = bits;
        t[0] = ~way[1];
        if (way[1]) begin
            t[2] = ~way[0];
        end else begin
            t[1] = ~way[0];
        end
        return t;
    endfunction : plru_touch

    always_comb begin
        logic [SET_W-1:0] set_idx;
        logic [TAG_W-1:0] tag;
        logic [1:0] hit_way;
        logic [1:0] way;
        set_idx = lookup_vpn[SET_W-1:0];
        tag = lookup_vpn[VPN_W-1:SET_W];
        way = 2'h0;
        hit = 1'b0;
        hit_way = 2'h0;
        next_state = state;
        // all ways compared in parallel
        for (int w = 0; w < CACHE_WAYS; w++) begin
            if (state.ent[set_idx][w].valid && state.ent[set_idx][w].tag == tag) begin
                hit = 1'b1;
                hit_way = w[1:0];
            end
        end
        hit_frame = state.ent[set_idx][hit_way].frame;
        hit_user = state.ent[set_idx][hit_way].user;
        hit_rw = state.ent[set_idx][hit_way].rw;
        hit_dirty = state.ent[set_idx][hit_way].dirty;
        if (touch && hit) begin
            next_state.plru[set_idx] = plru_touch(state.plru[set_idx], hit_way);
        end
        if (fill) begin
            // refilling an entry already present reuses its way, so no duplicates
            way = hit ? hit_way : (state.plru[set_idx][0] ? {1'b1, state.plru[set_idx][2]}
                                                         : {1'b0, state.plru[set_idx][1]});
            next_state.ent[set_idx][way] = '{valid: 1'b1, tag: tag, frame: fill_frame,
                user: fill_user, rw: fill_rw, dirty: fill_dirty};
            next_state.plru[set_idx] = plru_touch(state.plru[set_idx], way);
        end
        if (flush) begin
            for (int s = 0; s < SETS; s++) begin
                for (int w = 0; w < CACHE_WAYS; w++) begin
                    next_state.ent[s][w].valid = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    AST_FLUSH_EMPTIES: assert property (flush |=> !hit)
        else $error("translation cache hit after flush");
    AST_FILL_HITS: assert property ((fill && !flush)
        ##1 (lookup_vpn == $past(lookup_vpn)) |-> hit && hit_frame == $past(fill_frame))
        else $error("filled translation not found");
endmodule : translation_cache

// ---- rtl/two_level_paging_translation.sv ----
// paging unit: control words, translation cache lookup and two-level table walk
`timescale 1ns/100ps
module two_level_paging_translation import paging_pkg::*; (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic cr_write,
    input wire logic [1:0] cr_sel,
    input wire logic [31:0] cr_wdata,
    output logic [31:0] cr_rdata,
    output logic protection_on,
    output logic paging_on,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [LIN_W-1:0] req_linear,
    input wire logic req_write,
    input wire logic [1:0] req_cpl,
    output logic rsp_valid,
    output logic [PHYS_W-1:0] rsp_phys,
    output logic rsp_fault,
    output logic [2:0] rsp_error_code,
    output logic [7:0] rsp_vector,
    output logic mem_req,
    output logic [PHYS_W-1:0] mem_addr,
    output logic mem_write,
    output logic [31:0] mem_wdata,
    output logic mem_lock,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata
);
    typedef struct packed {
        walk_state_t st;
        logic req_ready;
        logic [LIN_W-1:0] lin;
        logic wr;
        logic user;
        logic prot_on;
        logic paging;
        logic [LIN_W-1:0] fault_addr;
        logic [FRAME_W-1:0] dir_base;
        logic [31:0] pde;
        logic mem_req;
        logic [PHYS_W-1:0] mem_addr;
        logic mem_write;
        logic [31:0] mem_wdata;
        logic mem_lock;
        logic rsp_valid;
        logic [PHYS_W-1:0] rsp_phys;
        logic rsp_fault;
        logic [2:0] rsp_code;
        logic [7:0] rsp_vec;
        logic [31:0] cr_rdata;
        logic fill;
        logic fill_dirty;
        logic [FRAME_W-1:0] fill_frame;
        logic fill_user;
        logic fill_rw;
        logic flush;
    } walk_t;
    walk_t state, next_state;

    logic hit, hit_user, hit_rw, hit_dirty;
    logic [FRAME_W-1:0] hit_frame;
    logic chk_present, chk_user_ok, chk_rw_ok, violation;
    logic [2:0] err_code;

    // entry address: base from bits 31..12, upper 8 bits of 32 dropped on the way out
    function automatic logic [PHYS_W-1:0] entry_addr(input logic [FRAME_W-1:0] base,
                                                      input logic [INDEX_W-1:0] index);
        return {base, index, 2'b00};
    endfunction : entry_addr

    translation_cache #(.SETS(CACHE_SETS)) cache (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .lookup_vpn(state.lin[LIN_W-1:PAGE_OFFSET_W]),
        .touch(state.st == ST_LOOKUP),
        .fill(state.fill),
        .fill_frame(state.fill_frame),
        .fill_user(state.fill_user),
        .fill_rw(state.fill_rw),
        .fill_dirty(state.fill_dirty),
        .flush(state.flush),
        .hit(hit),
        .hit_frame(hit_frame),
        .hit_user(hit_user),
        .hit_rw(hit_rw),
        .hit_dirty(hit_dirty)
    );

    protection_check prot (
        .present(chk_present),
        .user_ok(chk_user_ok),
        .rw_ok(chk_rw_ok),
        .user_access(state.user),
        .write_access(state.wr),
        .violation(violation),
        .err_code(err_code)
    );

    always_comb begin
        chk_present = (state.st == ST_LOOKUP) ? 1'b1 : mem_rdata[ENTRY_PRESENT];
        chk_user_ok = (state.st == ST_LOOKUP) ? hit_user
                    : (state.pde[ENTRY_US] & mem_rdata[ENTRY_US]);
        chk_rw_ok = (state.st == ST_LOOKUP) ? hit_rw
                  : (state.pde[ENTRY_RW] & mem_rdata[ENTRY_RW]);
    end

    always_comb begin
        logic finish;
        logic fault_now;
        logic [PHYS_W-1:0] phys_now;
        finish = 1'b0;
        fault_now = 1'b0;
        phys_now = state.lin[PHYS_W-1:0];
        next_state = state;
        next_state.rsp_valid = 1'b0;
        next_state.rsp_fault = 1'b0;
        next_state.rsp_vec = 8'h00;
        next_state.fill = 1'b0;
        next_state.flush = 1'b0;
        if (cr_write) begin
            case (cr_sel)
                SEL_MCW: begin
                    next_state.prot_on = cr_wdata[MCW_PROT_ON_BIT];
                    next_state.paging = cr_wdata[MCW_PAGING_BIT];
                end
                SEL_FAULT_ADDR: next_state.fault_addr = cr_wdata;
                SEL_DIR_BASE: begin
                    next_state.dir_base = cr_wdata[PHYS_W-1:PAGE_OFFSET_W];
                    next_state.flush = 1'b1;
                end
                default: ;
            endcase
        end
        case (cr_sel)
            SEL_MCW: next_state.cr_rdata = {state.paging, 30'h0, state.prot_on};
            SEL_FAULT_ADDR: next_state.cr_rdata = state.fault_addr;
            SEL_DIR_BASE: next_state.cr_rdata = {8'h00, state.dir_base, 12'h000};
            default: next_state.cr_rdata = 32'h0;
        endcase
        case (state.st)
            ST_IDLE: begin
                if (req_valid) begin
                    next_state.lin = req_linear;
                    next_state.wr = req_write;
                    next_state.user = (req_cpl == USER_LEVEL);
                    next_state.req_ready = 1'b0;
                    next_state.st = ST_LOOKUP;
                end
            end
            ST_LOOKUP: begin
                if (!(state.prot_on && state.paging)) begin
                    finish = 1'b1;
                // a write through a clean cached entry still walks to set the written bit
                end else if (hit && !(state.wr && !hit_dirty)) begin
                    fault_now = violation;
                    finish = !violation;
                    phys_now = {hit_frame, state.lin[PAGE_OFFSET_W-1:0]};
                end else begin
                    next_state.mem_req = 1'b1;
                    next_state.mem_write = 1'b0;
                    next_state.mem_lock = 1'b1;
                    next_state.mem_addr = entry_addr(state.dir_base,
                        state.lin[LIN_W-1:DIR_INDEX_LSB]);
                    next_state.st = ST_DIR_RD;
                end
            end
            ST_DIR_RD: begin
                if (mem_ack) begin
                    next_state.pde = mem_rdata;
                    next_state.mem_req = 1'b0;
                    if (!mem_rdata[ENTRY_PRESENT]) begin
                        fault_now = 1'b1;
                    end else if (!mem_rdata[ENTRY_ACCESSED]) begin
                        next_state.mem_req = 1'b1;
                        next_state.mem_write = 1'b1;
                        next_state.mem_wdata = mem_rdata | (32'h1 << ENTRY_ACCESSED);
                        next_state.st = ST_DIR_WR;
                    end else begin
                        next_state.mem_req = 1'b1;
                        next_state.mem_addr = entry_addr(mem_rdata[PHYS_W-1:ENTRY_ADDR_LSB],
                            state.lin[DIR_INDEX_LSB-1:TBL_INDEX_LSB]);
                        next_state.st = ST_TBL_RD;
                    end
                end
            end
            ST_DIR_WR: begin
                if (mem_ack) begin
                    // table base bits 31..12 with zero low bits, upper 8 truncated
                    next_state.mem_write = 1'b0;
                    next_state.mem_addr = entry_addr(state.pde[PHYS_W-1:ENTRY_ADDR_LSB],
                        state.lin[DIR_INDEX_LSB-1:TBL_INDEX_LSB]);
                    next_state.st = ST_TBL_RD;
                end
            end
            ST_TBL_RD: begin
                if (mem_ack) begin
                    next_state.mem_req = 1'b0;
                    next_state.fill_frame = mem_rdata[PHYS_W-1:ENTRY_ADDR_LSB];
                    next_state.fill_user = chk_user_ok;
                    next_state.fill_rw = chk_rw_ok;
                    next_state.fill_dirty = mem_rdata[ENTRY_WRITTEN] | state.wr;
                    phys_now = {mem_rdata[PHYS_W-1:ENTRY_ADDR_LSB],
                        state.lin[PAGE_OFFSET_W-1:0]};
                    if (!mem_rdata[ENTRY_PRESENT] || violation) begin
                        fault_now = 1'b1;
                    end else if (!mem_rdata[ENTRY_ACCESSED]
                                 || (state.wr && !mem_rdata[ENTRY_WRITTEN])) begin
                        next_state.mem_req = 1'b1;
                        next_state.mem_write = 1'b1;
                        next_state.mem_wdata = mem_rdata | (32'h1 << ENTRY_ACCESSED)
                            | ({31'h0, state.wr} << ENTRY_WRITTEN);
                        next_state.st = ST_TBL_WR;
                    end else begin
                        finish = 1'b1;
                        next_state.fill = 1'b1;
                    end
                end
            end
            ST_TBL_WR: begin
                phys_now = state.rsp_phys;
                if (mem_ack) begin
                    finish = 1'b1;
                    next_state.fill = 1'b1;
                end
            end
            default: next_state.st = ST_IDLE;
        endcase
        if (state.st == ST_TBL_RD && mem_ack) begin
            next_state.rsp_phys = phys_now;
        end
        if (finish || fault_now) begin
            next_state.mem_req = 1'b0;
            next_state.mem_write = 1'b0;
            next_state.mem_lock = 1'b0;
            next_state.rsp_valid = 1'b1;
            next_state.rsp_fault = fault_now;
            next_state.rsp_vec = fault_now ? PAGE_FAULT_VECTOR : 8'h00;
            next_state.rsp_phys = phys_now;
            next_state.rsp_code = err_code;
            next_state.req_ready = 1'b1;
            next_state.st = ST_IDLE;
            if (fault_now) begin
                next_state.fill = 1'b0;
                // hardware load wins over a software write in the same cycle
                next_state.fault_addr = state.lin;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
            state.req_ready <= 1'b1;
            state.fault_addr <= FAULT_ADDR_RESET;
            state.dir_base <= DIR_BASE_RESET;
            state.st <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign cr_rdata = state.cr_rdata;
    assign protection_on = state.prot_on;
    assign paging_on = state.paging;
    assign req_ready = state.req_ready;
    assign rsp_valid = state.rsp_valid;
    assign rsp_phys = state.rsp_phys;
    assign rsp_fault = state.rsp_fault;
    assign rsp_error_code = state.rsp_code;
    assign rsp_vector = state.rsp_vec;
    assign mem_req = state.mem_req;
    assign mem_addr = state.mem_addr;
    assign mem_write = state.mem_write;
    assign mem_wdata = state.mem_wdata;
    assign mem_lock = state.mem_lock;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence dir_absent_s;
        state.st == ST_DIR_RD && mem_ack && !mem_rdata[ENTRY_PRESENT];
    endsequence
    sequence fault_absent_s;
        rsp_valid && rsp_fault && !rsp_error_code[ERR_P] && rsp_vector == PAGE_FAULT_VECTOR;
    endsequence
    AST_DIR_ABSENT_FAULT: assert property (dir_absent_s |=> fault_absent_s)
        else $error("absent directory entry did not fault");
    AST_FAULT_ADDR: assert property (rsp_valid && rsp_fault
        |-> state.fault_addr == state.lin)
        else $error("fault address not captured");
    AST_DIR_INDEX: assert property ($rose(mem_req) && state.st == ST_DIR_RD
        |-> mem_addr == {state.dir_base, state.lin[31:22], 2'b00})
        else $error("directory entry address wrong");
    AST_TBL_INDEX: assert property (state.st == ST_TBL_RD && mem_req
        |-> mem_addr[11:2] == state.lin[21:12] && mem_addr[23:12] == state.pde[23:12])
        else $error("table entry address wrong");
    AST_LOCKED_WRITE: assert property (mem_req && mem_write |-> mem_lock && $past(mem_lock))
        else $error("entry update not locked");
    AST_ACCESSED_SET: assert property (mem_req && mem_write |-> mem_wdata[ENTRY_ACCESSED])
        else $error("accessed bit not set on update");
    AST_WRITTEN_SET: assert property (state.st == ST_TBL_WR && state.wr |-> mem_wdata[6])
        else $error("written bit not set before write");
    AST_REAL_MODE: assert property (rsp_valid && $past(state.st) == ST_LOOKUP
        && !($past(state.prot_on) && $past(state.paging))
        |-> !rsp_fault && rsp_phys == state.lin[23:0])
        else $error("untranslated address altered");
    AST_SUPER_NO_PROT: assert property (rsp_valid && rsp_fault && rsp_error_code[ERR_P]
        |-> rsp_error_code[ERR_US] && state.user)
        else $error("protection fault below level 3");
    AST_CR3_FLUSH: assert property (cr_write && cr_sel == SEL_DIR_BASE |=> state.flush
        && {8'h00, state.dir_base, 12'h000} == ($past(cr_wdata) & 32'h00ff_f000))
        else $error("directory base write did not flush");
    AST_NO_FILL_ON_FAULT: assert property (rsp_fault |-> !state.fill)
        else $error("faulting walk loaded cache");
endmodule : two_level_paging_translation

// ---- test/page_memory.sv ----
// behavioural system memory holding the page directory and page tables
`timescale 1ns/100ps
module page_memory (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic slow,
    input wire logic mem_req,
    input wire logic [23:0] mem_addr,
    input wire logic mem_write,
    input wire logic [31:0] mem_wdata,
    input wire logic mem_lock,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [logic [23:0]];
    int wait_cnt;
    // idle data toggles so a read taken outside the ack cycle never looks valid
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mem_ack <= 1'b0;
            mem_rdata <= 32'h5a5a_5a5a;
            wait_cnt = 0;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack) begin
                if (wait_cnt >= (slow ? 3 : 0)) begin
                    mem_ack <= 1'b1;
                    mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 32'h0000_0000;
                    if (mem_write) begin
                        mem[mem_addr] = mem_wdata;
                    end
                    wait_cnt = 0;
                end else begin
                    wait_cnt++;
                end
            end
        end
    end
endmodule : page_memory

// ---- test/tb_top.sv ----
// self-checking bench: control words, table walks, hits, faults and flushes
`timescale 1ns/100ps
`define CHECK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module tb_top import paging_pkg::*;;
    logic clk_sys = 1'b0, resetn = 1'b0, cr_write = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic [1:0] cr_sel = 2'h0, req_cpl = 2'h0;
    logic [31:0] cr_wdata = 32'h0, req_linear = 32'h0, cr_rdata, mem_wdata, mem_rdata;
    logic protection_on, paging_on, req_ready, rsp_valid, rsp_fault, mem_req, mem_write;
    logic mem_lock, mem_ack, slow = 1'b0, lock_seen = 1'b0;
    logic [23:0] rsp_phys, mem_addr;
    logic [2:0] rsp_error_code;
    logic [7:0] rsp_vector;
    int mismatches = 0, compares = 0, nacc = 0, a0;
    always #5 clk_sys = ~clk_sys;
    two_level_paging_translation u_two_level_paging_translation (.clk_sys(clk_sys),
        .resetn(resetn), .cr_write(cr_write), .cr_sel(cr_sel), .cr_wdata(cr_wdata),
        .cr_rdata(cr_rdata), .protection_on(protection_on), .paging_on(paging_on),
        .req_valid(req_valid), .req_ready(req_ready), .req_linear(req_linear),
        .req_write(req_write), .req_cpl(req_cpl), .rsp_valid(rsp_valid), .rsp_phys(rsp_phys),
        .rsp_fault(rsp_fault), .rsp_error_code(rsp_error_code), .rsp_vector(rsp_vector),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_write(mem_write), .mem_wdata(mem_wdata),
        .mem_lock(mem_lock), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    page_memory u_page_memory (.clk_sys(clk_sys), .resetn(resetn), .slow(slow),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_write(mem_write), .mem_wdata(mem_wdata),
        .mem_lock(mem_lock), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    always @(posedge clk_sys) begin
        if (mem_req && mem_ack) nacc++;
        if (mem_req && mem_lock) lock_seen = 1'b1;
    end
    task automatic results;
        $display("comparisons %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results
    task automatic cr_wr(input logic [1:0] sel, input logic [31:0] data);
        @(posedge clk_sys); #1;
        cr_write = 1'b1;
        cr_sel = sel;
        cr_wdata = data;
        @(posedge clk_sys); #1;
        cr_write = 1'b0;
    endtask : cr_wr
    task automatic cr_chk(input logic [1:0] sel, input logic [31:0] exp);
        cr_sel = sel;
        @(posedge clk_sys); #1;
        `CHECK(cr_rdata, exp)
    endtask : cr_chk
    // val is the physical address on success, the error code on a fault
    task automatic xl(input logic [31:0] lin, input logic wr, input logic [1:0] cpl,
                      input logic flt, input logic [23:0] val);
        int n;
        @(posedge clk_sys); #1;
        req_valid = 1'b1;
        req_linear = lin;
        req_write = wr;
        req_cpl = cpl;
        @(posedge clk_sys); #1;
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 100) begin
            @(posedge clk_sys); #1;
            n++;
        end
        `CHECK(rsp_valid, 1'b1)
        `CHECK({rsp_fault, flt ? {21'h0, rsp_error_code} : rsp_phys}, {flt, val})
        `CHECK(rsp_vector, flt ? 8'h0e : 8'h00)
    endtask : xl
    initial begin
        #200000;
        mismatches++;
        results();
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        #1 resetn = 1'b1;
        `CHECK({req_ready, protection_on, paging_on}, 3'b100)
        xl(32'hab12_3456, 1'b0, 2'h3, 1'b0, 24'h12_3456);
        cr_wr(2'h3, 32'hff00_1abc);
        cr_chk(2'h3, 32'h0000_1000);
        cr_chk(2'h1, 32'h0000_0000);
        cr_wr(2'h2, 32'h1234_5678);
        cr_chk(2'h2, 32'h1234_5678);
        cr_wr(2'h0, 32'h8000_0001);
        `CHECK({protection_on, paging_on}, 2'b11)
        u_page_memory.mem[24'h001004] = 32'h0000_2007;
        u_page_memory.mem[24'h001008] = 32'h0000_2003;
        u_page_memory.mem[24'h002008] = 32'hff0a_5e07;
        u_page_memory.mem[24'h002010] = 32'h0000_6005;
        xl(32'h0040_2345, 1'b0, 2'h3, 1'b0, 24'h0a_5345);
        `CHECK(u_page_memory.mem[24'h001004], 32'h0000_2027)
        `CHECK(u_page_memory.mem[24'h002008], 32'hff0a_5e27)
        a0 = nacc;
        xl(32'h0040_2345, 1'b0, 2'h3, 1'b0, 24'h0a_5345);
        `CHECK(nacc, a0)
        slow = 1'b1;
        xl(32'h0040_2345, 1'b1, 2'h3, 1'b0, 24'h0a_5345);
        `CHECK(u_page_memory.mem[24'h002008], 32'hff0a_5e67)
        `CHECK(lock_seen, 1'b1)
        xl(32'h0040_4abc, 1'b1, 2'h3, 1'b1, 24'h00_0007);
        cr_chk(2'h2, 32'h0040_4abc);
        xl(32'h0040_4abc, 1'b1, 2'h0, 1'b0, 24'h00_6abc);
        xl(32'h0080_2010, 1'b0, 2'h3, 1'b1, 24'h00_0005);
        xl(32'h00c0_0000, 1'b0, 2'h3, 1'b1, 24'h00_0004);
        a0 = nacc;
        xl(32'h00c0_0000, 1'b0, 2'h0, 1'b1, 24'h00_0000);
        `CHECK(nacc > a0, 1'b1)
        slow = 1'b0;
        cr_wr(2'h3, 32'h0000_1000);
        a0 = nacc;
        xl(32'h0040_2345, 1'b0, 2'h3, 1'b0, 24'h0a_5345);
        `CHECK(nacc > a0, 1'b1)
        results();
    end
endmodule : tb_top
